//--- rtl/atf_cmd.sv
// command interpreter: accumulator transfers, multiply, flag clear, interrupt enables
// assumes all inputs come from logic on core_clk; host strobes one byte per handshake
`timescale 1ns/1ns
`include "atf_regs.svh"

// Behaviour
// RULE1: frame is address, command, type, motor/bank, value msb first, checksum.
// RULE2: checksum is modulo-256 sum of first eight bytes, same for replies.
// RULE3: code 33 type 2 multiplies accumulator by X register into accumulator.
// RULE4: code 34 writes accumulator into axis parameter type for given motor.
// RULE5: code 35 writes accumulator to global parameter; banks 0,2,3 only.
// RULE6: code 36 clears error flags chosen by type; motor, value ignored.
// RULE7: clear type 0 all, 1 timeout, 2 alarm, 3 deviation, 4 position, 5 shutdown.
// RULE8: code 25 sets the enable of the interrupt numbered by type.
// RULE9: code 25 with number 255 sets the global interrupt enable.
// RULE10: code 26 clears the enable of the interrupt numbered by type.
// RULE11: code 26 with number 255 clears the global interrupt enable.
// RULE12: successful commands reply with status 100, value don't care.
module atf_cmd #(
  parameter logic [7:0] DEV_ADDR = 8'h01,
  parameter logic [7:0] HOST_ADDR = 8'h02
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_byte,
  input wire logic accu_wr,
  input wire logic [31:0] accu_wdata,
  input wire logic xreg_wr,
  input wire logic [31:0] xreg_wdata,
  input wire logic [4:0] err_set,
  output logic [31:0] accu,
  output logic [4:0] err_flags,
  output logic [atf_pkg::NUM_IRQ-1:0] irq_en,
  output logic irq_global_en,
  output atf_pkg::atf_par_t par_wr
);

  atf_pkg::atf_st_t s_q, s_d;

  function automatic logic [7:0] frame_sum(input atf_pkg::atf_frame_t f);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < `ATF_SUM_IDX; i++) begin
      acc = acc + f[i];
    end
    return acc;
  endfunction

  logic [7:0] f_cmd, f_type, f_sel;
  logic sum_ok, addr_ok, exec_go;
  assign f_cmd = s_q.req[`ATF_POS_CMD];
  assign f_type = s_q.req[`ATF_POS_TYPE];
  assign f_sel = s_q.req[`ATF_POS_MOT];
  assign sum_ok = frame_sum(s_q.req) == s_q.req[`ATF_SUM_IDX]; // see RULE2
  assign addr_ok = s_q.req[`ATF_POS_ADDR] == DEV_ADDR;
  assign exec_go = s_q.state == atf_pkg::ATF_EXEC && addr_ok && sum_ok;

  always_comb begin
    logic [7:0] status;
    logic [4:0] clr;
    status = `ATF_ST_OK;
    clr = 5'h00;
    s_d = s_q;
    s_d.par.axis_wr = 1'b0;
    s_d.par.glob_wr = 1'b0;
    if (accu_wr) begin
      s_d.accu = accu_wdata;
    end
    if (xreg_wr) begin
      s_d.xreg = xreg_wdata;
    end
    case (s_q.state)
      atf_pkg::ATF_RX: begin
        if (rx_valid) begin
          s_d.req[s_q.cnt] = rx_byte; // see RULE1
          if (s_q.cnt == `ATF_LAST_IDX) begin
            s_d.cnt = 4'h0;
            s_d.state = atf_pkg::ATF_EXEC;
          end else begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
        end
      end
      atf_pkg::ATF_EXEC: begin
        if (!sum_ok) begin
          status = `ATF_ST_BADSUM;
        end else begin
          case (f_cmd)
            `ATF_CMD_ACCU_XREG_CALC_CMD: begin
              // only the multiply operation lives in this block
              if (f_type == `ATF_TYPE_MUL) begin
                s_d.accu = 32'(s_q.accu * s_q.xreg); // see RULE3
              end else begin
                status = `ATF_ST_BADTYPE;
              end
            end
            `ATF_CMD_AXIS: begin
              s_d.par = '{1'b1, 1'b0, f_type, f_sel, s_q.accu}; // see RULE4
            end
            `ATF_CMD_GLOB: begin
              if (f_sel == 8'h00 || f_sel == 8'h02 || f_sel == 8'h03) begin
                s_d.par = '{1'b0, 1'b1, f_type, f_sel, s_q.accu}; // see RULE5
              end else begin
                status = `ATF_ST_BADVAL;
              end
            end
            `ATF_CMD_CLEAR: begin
              if (f_type == `ATF_CLR_ALL) begin
                clr = 5'h1f; // see RULE7
              end else if (f_type <= `ATF_CLR_LAST) begin
                clr[3'(f_type - 8'h01)] = 1'b1; // see RULE6
              end else begin
                status = `ATF_ST_BADTYPE;
              end
            end
            `ATF_CMD_IEN: begin
              if (f_type == `ATF_IRQ_GLOBAL) begin
                s_d.gien = 1'b1; // see RULE9
              end else if (f_type < 8'(atf_pkg::NUM_IRQ)) begin
                s_d.ien[5'(f_type)] = 1'b1; // see RULE8
              end else begin
                status = `ATF_ST_BADTYPE;
              end
            end
            `ATF_CMD_IDIS: begin
              if (f_type == `ATF_IRQ_GLOBAL) begin
                s_d.gien = 1'b0; // see RULE11
              end else if (f_type < 8'(atf_pkg::NUM_IRQ)) begin
                s_d.ien[5'(f_type)] = 1'b0; // see RULE10
              end else begin
                status = `ATF_ST_BADTYPE;
              end
            end
            default: status = `ATF_ST_BADCMD;
          endcase
        end
        // a failed frame must not move anything, so undo side effects on error
        if (status != `ATF_ST_OK) begin
          s_d.par = s_q.par;
          s_d.par.axis_wr = 1'b0;
          s_d.par.glob_wr = 1'b0;
        end
        // frames for another address are dropped silently so the bus stays free
        if (!addr_ok) begin
          s_d = s_q;
          // a load from outside in the same cycle must not be lost with the frame
          if (accu_wr) begin
            s_d.accu = accu_wdata;
          end
          if (xreg_wr) begin
            s_d.xreg = xreg_wdata;
          end
          s_d.par.axis_wr = 1'b0;
          s_d.par.glob_wr = 1'b0;
          clr = 5'h00;
          s_d.state = atf_pkg::ATF_RX;
        end else begin
          s_d.rep = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, f_cmd, status, DEV_ADDR, HOST_ADDR};
          s_d.rep[`ATF_SUM_IDX] = frame_sum(s_d.rep); // see RULE12
          s_d.state = atf_pkg::ATF_TX;
        end
      end
      atf_pkg::ATF_TX: begin
        if (tx_ready) begin
          if (s_q.cnt == `ATF_LAST_IDX) begin
            s_d.cnt = 4'h0;
            s_d.state = atf_pkg::ATF_RX;
          end else begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
        end
      end
      default: begin
        s_d.state = atf_pkg::ATF_RX;
        s_d.cnt = 4'h0;
      end
    endcase
    // a flag raised in the clearing cycle survives: set wins
    s_d.flags = (s_q.flags & ~clr) | err_set;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.state <= atf_pkg::ATF_RX;
      s_q.accu <= `ATF_ACCU_RST;
      s_q.xreg <= `ATF_XREG_RST;
      s_q.flags <= `ATF_FLAGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_ready = s_q.state == atf_pkg::ATF_RX;
  assign tx_valid = s_q.state == atf_pkg::ATF_TX;
  assign tx_byte = s_q.rep[s_q.cnt];
  assign accu = s_q.accu;
  assign err_flags = s_q.flags;
  assign irq_en = s_q.ien;
  assign irq_global_en = s_q.gien;
  assign par_wr = s_q.par;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  frame_complete_a: assert property ( // see RULE1
    s_q.state == atf_pkg::ATF_RX && rx_valid && s_q.cnt == `ATF_LAST_IDX
    |=> s_q.state != atf_pkg::ATF_RX || !addr_ok)
    else $error("ninth byte did not start execution");
  reply_sum_a: assert property ( // see RULE2
    tx_valid |-> s_q.rep[`ATF_SUM_IDX] == frame_sum(s_q.rep))
    else $error("reply checksum wrong");
  mul_result_a: assert property ( // see RULE3
    exec_go && f_cmd == `ATF_CMD_ACCU_XREG_CALC_CMD && f_type == `ATF_TYPE_MUL
    |=> accu == 32'($past(s_q.accu) * $past(s_q.xreg)) || $past(accu_wr))
    else $error("multiply result wrong");
  axis_write_a: assert property ( // see RULE4
    par_wr.axis_wr |-> $past(exec_go) && par_wr.data == $past(s_q.accu)
      && $past(f_cmd) == `ATF_CMD_AXIS)
    else $error("axis write without command or with wrong data");
  glob_bank_a: assert property ( // see RULE5
    par_wr.glob_wr |-> par_wr.sel inside {8'h00, 8'h02, 8'h03} && $past(exec_go))
    else $error("global write to illegal bank");
  flag_clear_a: assert property ( // see RULE7
    exec_go && f_cmd == `ATF_CMD_CLEAR && f_type == 8'h01
    |=> err_flags[`ATF_FLG_TIMEOUT] == $past(err_set[`ATF_FLG_TIMEOUT]))
    else $error("timeout flag not cleared");
  flag_all_a: assert property ( // see RULE6
    exec_go && f_cmd == `ATF_CMD_CLEAR && f_type == `ATF_CLR_ALL |=> err_flags == $past(err_set))
    else $error("clear all left flags set");
  irq_set_a: assert property ( // see RULE8
    exec_go && f_cmd == `ATF_CMD_IEN && f_type < 8'h20 |=> irq_en[$past(f_type[4:0])])
    else $error("interrupt enable not set");
  irq_clear_a: assert property ( // see RULE10
    exec_go && f_cmd == `ATF_CMD_IDIS && f_type < 8'h20 |=> !irq_en[$past(f_type[4:0])])
    else $error("interrupt enable not cleared");
  global_on_a: assert property ( // see RULE9
    exec_go && f_cmd == `ATF_CMD_IEN && f_type == `ATF_IRQ_GLOBAL |=> irq_global_en)
    else $error("global enable not set");
  global_off_a: assert property ( // see RULE11
    exec_go && f_cmd == `ATF_CMD_IDIS && f_type == `ATF_IRQ_GLOBAL |=> !irq_global_en)
    else $error("global enable not cleared");
  reply_ok_a: assert property ( // see RULE12
    exec_go && f_cmd == `ATF_CMD_AXIS |=> tx_valid && s_q.rep[2] == `ATF_ST_OK)
    else $error("successful command without ok reply");

  cover property (exec_go && f_cmd == `ATF_CMD_ACCU_XREG_CALC_CMD && f_type == `ATF_TYPE_MUL);
  cover property (par_wr.glob_wr);
  cover property (tx_valid && tx_ready && s_q.cnt == `ATF_LAST_IDX);
endmodule

//--- rtl/atf_pkg.sv
// types of the accumulator-transfer / flag / interrupt command interpreter
// assumes atf_regs.svh supplies the numeric constants
package atf_pkg;
  localparam int NUM_IRQ = 32;

  typedef enum logic [1:0] {ATF_RX, ATF_EXEC, ATF_TX} atf_state_t;

  typedef logic [8:0][7:0] atf_frame_t;

  typedef struct packed {
    logic axis_wr;
    logic glob_wr;
    logic [7:0] num;
    logic [7:0] sel;
    logic [31:0] data;
  } atf_par_t;

  typedef struct packed {
    atf_state_t state;
    logic [3:0] cnt;
    atf_frame_t req;
    atf_frame_t rep;
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [4:0] flags;
    logic [NUM_IRQ-1:0] ien;
    logic gien;
    atf_par_t par;
  } atf_st_t;
endpackage

//--- rtl/atf_regs.svh
// constants of the accumulator-transfer / flag / interrupt command interpreter
// assumes nine-byte frames delivered one byte per handshake on core_clk
`ifndef ATF_REGS_SVH
`define ATF_REGS_SVH

`define ATF_FRAME_LEN 4'h9
`define ATF_LAST_IDX 4'h8
`define ATF_SUM_IDX 8
// request byte positions
`define ATF_POS_ADDR 0
`define ATF_POS_CMD 1
`define ATF_POS_TYPE 2
`define ATF_POS_MOT 3
// instruction codes
`define ATF_CMD_ACCU_XREG_CALC_CMD 8'h21
`define ATF_CMD_AXIS 8'h22
`define ATF_CMD_GLOB 8'h23
`define ATF_CMD_CLEAR 8'h24
`define ATF_CMD_IEN 8'h19
`define ATF_CMD_IDIS 8'h1a
// type / selector codes
`define ATF_TYPE_MUL 8'h02
`define ATF_IRQ_GLOBAL 8'hff
`define ATF_CLR_ALL 8'h00
`define ATF_CLR_LAST 8'h05
// reply status codes
`define ATF_ST_OK 8'h64
`define ATF_ST_BADSUM 8'h01
`define ATF_ST_BADCMD 8'h02
`define ATF_ST_BADTYPE 8'h03
`define ATF_ST_BADVAL 8'h04
// error flag bit positions
`define ATF_FLG_TIMEOUT 0
`define ATF_FLG_ALARM 1
`define ATF_FLG_DEVIATION 2
`define ATF_FLG_POSITION 3
`define ATF_FLG_SHUTDOWN 4
// reset values
`define ATF_ACCU_RST 32'h0000_0000
`define ATF_XREG_RST 32'h0000_0000
`define ATF_FLAGS_RST 5'h00

`endif

//--- verification/atf_host.sv
// host model: sends request frames and collects replies of the command interpreter
// assumes the device samples on rising core_clk; the model moves at falling edges
`timescale 1ns/1ns
module atf_host (
  input wire logic core_clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_byte
);
  int stall = 0;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end
  // a nonzero value byte: these commands must ignore it
  task automatic send(input logic [7:0] a, c, t, m, bias);
    logic [7:0] f [9];
    f = '{a, c, t, m, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h00};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    f[8] += bias;
    for (int i = 0; i < 9; i++) begin
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_byte = f[i];
      while (rx_ready !== 1'b1) @(negedge core_clk);
      @(posedge core_clk);
    end
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte; // released line must not show the stale byte
  endtask
  task automatic recv(output logic [7:0] r [9]);
    for (int i = 0; i < 9; i++) begin
      @(negedge core_clk);
      // a stalled host holds ready low for a few cycles before taking the byte
      if (stall != 0) begin
        tx_ready = 1'b0;
        repeat (stall) @(negedge core_clk);
      end
      tx_ready = 1'b1;
      for (int k = 0; k < 50 && tx_valid !== 1'b1; k++) @(negedge core_clk);
      r[i] = tx_byte;
      @(posedge core_clk);
    end
    @(negedge core_clk);
    tx_ready = 1'b0;
  endtask
endmodule

//--- verification/testbench.sv
// self-checking bench of the command interpreter, driven through the host model
// assumes device address 01 and host address 02 as the design defaults
`timescale 1ns/1ns
module testbench;
  logic core_clk, arst_n, rx_valid, rx_ready, tx_valid, tx_ready;
  logic accu_wr, xreg_wr, irq_global_en;
  logic [7:0] rx_byte, tx_byte;
  logic [31:0] accu_wdata, xreg_wdata, accu;
  logic [4:0] err_set, err_flags;
  logic [atf_pkg::NUM_IRQ-1:0] irq_en;
  atf_pkg::atf_par_t par_wr;
  atf_pkg::atf_par_t last_par = '0;
  int mismatches = 0;
  int n_compared = 0;
  int n_wr = 0;

  atf_cmd DUT (.core_clk(core_clk), .arst_n(arst_n), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .accu_wr(accu_wr), .accu_wdata(accu_wdata), .xreg_wr(xreg_wr),
    .xreg_wdata(xreg_wdata), .err_set(err_set), .accu(accu), .err_flags(err_flags),
    .irq_en(irq_en), .irq_global_en(irq_global_en), .par_wr(par_wr));
  atf_host host (.core_clk(core_clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (par_wr.axis_wr || par_wr.glob_wr) begin
      n_wr++;
      last_par <= par_wr;
    end
  end

  task automatic chk(input logic [63:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] c, t, m, bias, st);
    logic [7:0] r [9];
    logic [7:0] e [9];
    e = '{8'h02, 8'h01, st, c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) e[8] += e[i];
    host.send(8'h01, c, t, m, bias);
    host.recv(r);
    for (int i = 0; i < 9; i++) chk(64'(r[i]), 64'(e[i]));
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge core_clk);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    int w;
    logic [4:0] ef;
    arst_n = 1'b0;
    {accu_wr, xreg_wr, err_set} = '0;
    accu_wdata = 32'h0000_0007;
    xreg_wdata = 32'h0000_0006;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    {accu_wr, xreg_wr} = 2'b11;
    @(negedge core_clk);
    {accu_wr, xreg_wr} = 2'b00;
    cmd(8'h21, 8'h02, 8'h00, 8'h00, 8'h64);
    chk(64'(accu), 64'h2a);
    // corrupted checksum: refused, accumulator untouched
    cmd(8'h21, 8'h02, 8'h00, 8'h01, 8'h01);
    chk(64'(accu), 64'h2a);
    host.stall = 2;
    cmd(8'h22, 8'h05, 8'h01, 8'h00, 8'h64);
    host.stall = 0;
    chk(64'(last_par), 64'({1'b1, 1'b0, 8'h05, 8'h01, 32'h2a}));
    for (int b = 0; b < 4; b++) begin
      w = n_wr;
      cmd(8'h23, 8'h2a, 8'(b), 8'h00, (b == 1) ? 8'h04 : 8'h64);
      chk(64'(n_wr - w), (b == 1) ? 64'h0 : 64'h1);
      if (b != 1) chk(64'(last_par), 64'({2'b01, 8'h2a, 8'(b), 32'h2a}));
    end
    for (int t = 0; t < 6; t++) begin
      @(negedge core_clk);
      err_set = 5'h1f;
      @(negedge core_clk);
      err_set = 5'h00;
      cmd(8'h24, 8'(t), 8'h07, 8'h00, 8'h64);
      ef = (t == 0) ? 5'h00 : (5'h1f & ~(5'h01 << (t - 1)));
      chk(64'(err_flags), 64'(ef));
    end
    cmd(8'h19, 8'h03, 8'h00, 8'h00, 8'h64);
    chk(64'(irq_en), 64'h8);
    cmd(8'h19, 8'hff, 8'h00, 8'h00, 8'h64);
    chk(64'({irq_global_en, irq_en}), 64'h1_0000_0008);
    cmd(8'h19, 8'h28, 8'h00, 8'h00, 8'h03);
    cmd(8'h1a, 8'h03, 8'h00, 8'h00, 8'h64);
    chk(64'({irq_global_en, irq_en}), 64'h1_0000_0000);
    cmd(8'h1a, 8'hff, 8'h00, 8'h00, 8'h64);
    chk(64'(irq_global_en), 64'h0);
    // frame for another address: no reply at all
    host.send(8'h05, 8'h21, 8'h02, 8'h00, 8'h00);
    repeat (6) @(negedge core_clk);
    chk(64'({tx_valid, rx_ready}), 64'h1);
    chk(64'(accu), 64'h2a);
    // mid-run reset: back to idle with the registers cleared, then one command
    @(negedge core_clk);
    arst_n = 1'b0;
    @(negedge core_clk);
    chk(64'({tx_valid, rx_ready, accu, err_flags}), 64'h20_0000_0000);
    arst_n = 1'b1;
    cmd(8'h19, 8'h00, 8'h00, 8'h00, 8'h64);
    chk(64'({irq_global_en, irq_en}), 64'h1);
    tally_and_finish;
  end
endmodule
